// ==== src/spd_pkg.sv ====
// Package with constants and types for the sleep power-down controller
package spd_pkg;
  // Register map (word index on the plain register port)
  localparam logic [3:0] SPD_REG_REGCTL = 4'h0;
  localparam logic [3:0] SPD_REG_STATUS = 4'h1;
  localparam logic [3:0] SPD_REG_CONFIG = 4'h2;
  localparam logic [3:0] SPD_REG_WAKE = 4'h3;
  // Regulator control fields
  localparam int SPD_REGCTL_RSVD_BIT = 0;
  localparam int SPD_REGCTL_LP_BIT = 1;
  localparam logic [7:0] SPD_REGCTL_RESET = 8'h01;
  // Status fields
  localparam int SPD_ST_PD_BIT = 0;
  localparam int SPD_ST_TO_BIT = 1;
  localparam int SPD_ST_ASLEEP_BIT = 2;
  localparam int SPD_ST_REGLP_BIT = 3;
  // Config fields
  localparam int SPD_CFG_WDT_SLEEP_BIT = 0;
  localparam int SPD_CFG_OSC_LSB = 1;
  localparam int SPD_CFG_TWOSPEED_BIT = 4;
  localparam int SPD_CFG_UNREG_BIT = 5;
  localparam logic [7:0] SPD_CFG_RESET = 8'h00;
  // Oscillator mode codes
  localparam logic [2:0] SPD_OSC_EXT = 3'h0;
  localparam logic [2:0] SPD_OSC_INT = 3'h1;
  localparam logic [2:0] SPD_OSC_RC = 3'h2;
  localparam logic [2:0] SPD_OSC_XTAL_LOW = 3'h3;
  localparam logic [2:0] SPD_OSC_XTAL_MED = 3'h4;
  localparam logic [2:0] SPD_OSC_XTAL_HIGH = 3'h5;
  // Timing
  localparam int SPD_CLK_MHZ = 20;
  localparam int SPD_OST_PERIODS = 1024;
  localparam logic [10:0] SPD_OST_CYCLES = 11'(SPD_OST_PERIODS);
  localparam int SPD_REG_STAB_US = 5;
  localparam logic [10:0] SPD_REG_STAB_CYCLES = 11'(SPD_REG_STAB_US * SPD_CLK_MHZ);
  localparam logic [14:0] SPD_ISR_VECTOR = 15'h0004;
  localparam int SPD_IRQ_W = 8;
  typedef enum logic [2:0] {
    SPD_RUN, SPD_SLEEP, SPD_SYNC, SPD_OST, SPD_STAB, SPD_RESUME
  } spd_state_t;
endpackage

// ==== src/spd_sleep_ctrl.sv ====
// Sleep power-down controller: entry, wake, status flags and regulator mode
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module spd_sleep_ctrl
  import spd_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic SLEEP_EXEC,
  input wire logic CLRWDT_EXEC,
  input wire logic [14:0] CORE_PC,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic [SPD_IRQ_W-1:0] IRQ_EVENT,
  input wire logic [SPD_IRQ_W-1:0] IRQ_ENABLE,
  input wire logic [SPD_IRQ_W-1:0] IRQ_FLAG_CLR,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic EXTERNAL_RESET_PIN,
  input wire logic EXTERNAL_RESET_EN,
  input wire logic BROWNOUT_RESET,
  input wire logic BROWNOUT_EN,
  input wire logic POWER_ON_RESET,
  input wire logic LP_INCOMPAT_ACTIVE,
  input wire logic TIMER1_SRC_SLEEP_OK,
  input wire logic CONVERTER_DEDICATED_OSC,
  input wire logic [7:0] IO_OUT,
  input wire logic [7:0] IO_OE,
  output logic CORE_CLK_EN,
  output logic DEVICE_RESET,
  output logic WATCHDOG_CLEAR,
  output logic WATCHDOG_RUN,
  output logic LOW_FREQ_INTERNAL_OSC_EN,
  output logic TIMER1_RUN,
  output logic CONVERTER_RUN,
  output logic [7:0] IO_PIN_OUT,
  output logic [7:0] IO_PIN_OE,
  output logic PREFETCH_REQ,
  output logic [14:0] PREFETCH_ADDR,
  output logic VECTOR_REQ,
  output logic [14:0] VECTOR_ADDR,
  output logic REGULATOR_LOWPOWER,
  output logic POWERDOWN_FLAG_N,
  output logic TIMEOUT_FLAG_N,
  output logic [SPD_IRQ_W-1:0] IRQ_FLAG
);

  ////////////////////////////////////////////////////////////////////////////
  spd_state_t state;
  logic [7:0] cfg;
  logic regulator_lowpower_sel;
  logic [10:0] dly_cnt;
  logic wake_meta;
  logic wake_sync;
  logic [1:0] wdt_pipe;
  logic used_lp;
  logic global_at_wake;
  logic full_reset;
  logic irq_pending;
  logic wake_raw;
  logic [2:0] osc_mode;
  logic need_ost;
  logic unregulated;

  assign osc_mode = cfg[SPD_CFG_OSC_LSB +: 3];
  assign unregulated = cfg[SPD_CFG_UNREG_BIT];
  // Two-speed start-up hides the crystal delay
  assign need_ost = (osc_mode == SPD_OSC_XTAL_LOW || osc_mode == SPD_OSC_XTAL_MED ||
                     osc_mode == SPD_OSC_XTAL_HIGH) && !cfg[SPD_CFG_TWOSPEED_BIT];
  assign irq_pending = |(IRQ_FLAG & IRQ_ENABLE);
  assign wake_raw = irq_pending || WATCHDOG_TIMEOUT;
  assign full_reset = POWER_ON_RESET || (BROWNOUT_RESET && BROWNOUT_EN) ||
                      (EXTERNAL_RESET_PIN && EXTERNAL_RESET_EN);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: set wins over a simultaneous clear
  genvar gi;
  generate
    for (gi = 0; gi < SPD_IRQ_W; gi++) begin : g_flag
      always_ff @(posedge CORE_CLK) begin
        if (RESET || full_reset) begin
          IRQ_FLAG[gi] <= 1'b0;
        end else if (IRQ_EVENT[gi]) begin
          IRQ_FLAG[gi] <= 1'b1;
        end else if (IRQ_FLAG_CLR[gi]) begin
          IRQ_FLAG[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Wake synchroniser; first stage feeds only the second
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
      wdt_pipe <= 2'b00;
    end else begin
      wake_meta <= wake_raw;
      wake_sync <= wake_meta;
      // Cause kept in step with the sync, so a one-cycle time-out still counts
      wdt_pipe <= {wdt_pipe[0], WATCHDOG_TIMEOUT};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge CORE_CLK) begin
    if (RESET || full_reset) begin
      state <= SPD_RUN;
      dly_cnt <= 11'h000;
      used_lp <= 1'b0;
      global_at_wake <= 1'b0;
    end else begin
      case (state)
        SPD_RUN: begin
          // Pending enabled interrupt turns the instruction into a no-op
          if (SLEEP_EXEC && !irq_pending) begin
            state <= SPD_SLEEP;
            used_lp <= regulator_lowpower_sel && !LP_INCOMPAT_ACTIVE && !unregulated;
          end
        end
        SPD_SLEEP: begin
          // A wake arriving during entry still completes entry first
          if (wake_sync) begin
            state <= SPD_SYNC;
            global_at_wake <= GLOBAL_IRQ_ENABLE;
          end
        end
        SPD_SYNC: begin
          if (need_ost) begin
            state <= SPD_OST;
            dly_cnt <= SPD_OST_CYCLES - 11'h001;
          end else if (used_lp) begin
            state <= SPD_STAB;
            dly_cnt <= SPD_REG_STAB_CYCLES - 11'h001;
          end else begin
            state <= SPD_RESUME;
          end
        end
        SPD_OST: begin
          if (dly_cnt == 11'h000) begin
            if (used_lp) begin
              state <= SPD_STAB;
              dly_cnt <= SPD_REG_STAB_CYCLES - 11'h001;
            end else begin
              state <= SPD_RESUME;
            end
          end else begin
            dly_cnt <= dly_cnt - 11'h001;
          end
        end
        SPD_STAB: begin
          if (dly_cnt == 11'h000) begin
            state <= SPD_RESUME;
          end else begin
            dly_cnt <= dly_cnt - 11'h001;
          end
        end
        SPD_RESUME: begin
          state <= SPD_RUN;
        end
        default: begin
          state <= SPD_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags and clock gate
  always_ff @(posedge CORE_CLK) begin
    if (RESET || full_reset) begin
      POWERDOWN_FLAG_N <= 1'b1;
      TIMEOUT_FLAG_N <= 1'b1;
      CORE_CLK_EN <= 1'b1;
    end else begin
      if (state == SPD_RUN && SLEEP_EXEC && !irq_pending) begin
        POWERDOWN_FLAG_N <= 1'b0;
        TIMEOUT_FLAG_N <= 1'b1;
        CORE_CLK_EN <= 1'b0;
      end else if (state == SPD_RESUME) begin
        CORE_CLK_EN <= 1'b1;
      end
      if (state == SPD_SLEEP && wake_sync && wdt_pipe[1]) begin
        TIMEOUT_FLAG_N <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog control, clocks kept alive, regulator mode
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      WATCHDOG_CLEAR <= 1'b1;
      WATCHDOG_RUN <= 1'b1;
      LOW_FREQ_INTERNAL_OSC_EN <= 1'b1;
      TIMER1_RUN <= 1'b1;
      CONVERTER_RUN <= 1'b1;
      REGULATOR_LOWPOWER <= 1'b0;
    end else begin
      WATCHDOG_CLEAR <= full_reset || CLRWDT_EXEC ||
                        (state == SPD_RUN && SLEEP_EXEC && !irq_pending) ||
                        (state == SPD_SLEEP && wake_sync) || state == SPD_OST;
      WATCHDOG_RUN <= (state == SPD_RUN) || cfg[SPD_CFG_WDT_SLEEP_BIT];
      LOW_FREQ_INTERNAL_OSC_EN <= 1'b1;
      TIMER1_RUN <= (state == SPD_RUN) || TIMER1_SRC_SLEEP_OK;
      CONVERTER_RUN <= (state == SPD_RUN) || CONVERTER_DEDICATED_OSC;
      // Incompatible peripheral forces normal mode even mid-sleep
      REGULATOR_LOWPOWER <= (state == SPD_SLEEP) && used_lp &&
                            !LP_INCOMPAT_ACTIVE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins held, prefetch and vector, reset out
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      IO_PIN_OUT <= 8'h00;
      IO_PIN_OE <= 8'h00;
      PREFETCH_REQ <= 1'b0;
      PREFETCH_ADDR <= 15'h0000;
      VECTOR_REQ <= 1'b0;
      VECTOR_ADDR <= SPD_ISR_VECTOR;
      DEVICE_RESET <= 1'b0;
    end else begin
      if (state == SPD_RUN) begin
        IO_PIN_OUT <= IO_OUT;
        IO_PIN_OE <= IO_OE;
      end
      PREFETCH_REQ <= SLEEP_EXEC && state == SPD_RUN;
      if (SLEEP_EXEC && state == SPD_RUN) begin
        PREFETCH_ADDR <= CORE_PC + 15'h0001;
      end
      // Vector only after the prefetched instruction runs; core sequences it
      // A time-out wake with nothing pending runs on in line
      VECTOR_REQ <= (state == SPD_RESUME) && global_at_wake &&
                    irq_pending;
      VECTOR_ADDR <= SPD_ISR_VECTOR;
      DEVICE_RESET <= full_reset && state != SPD_RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      regulator_lowpower_sel <= SPD_REGCTL_RESET[SPD_REGCTL_LP_BIT];
      cfg <= SPD_CFG_RESET;
    end else if (REG_WR) begin
      if (REG_ADDR == SPD_REG_REGCTL) begin
        regulator_lowpower_sel <= REG_WDATA[SPD_REGCTL_LP_BIT];
      end else if (REG_ADDR == SPD_REG_CONFIG) begin
        cfg <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        SPD_REG_REGCTL: REG_RDATA <= {6'h00, regulator_lowpower_sel, 1'b1};
        SPD_REG_STATUS: REG_RDATA <= {4'h0, REGULATOR_LOWPOWER, state != SPD_RUN,
                                      TIMEOUT_FLAG_N, POWERDOWN_FLAG_N};
        SPD_REG_CONFIG: REG_RDATA <= cfg;
        SPD_REG_WAKE: REG_RDATA <= IRQ_FLAG & IRQ_ENABLE;
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_entry_flags;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == SPD_RUN && SLEEP_EXEC && !irq_pending && !full_reset) |=>
      (!POWERDOWN_FLAG_N && !CORE_CLK_EN && TIMEOUT_FLAG_N);
  endproperty
  a_entry_flags: assert property (p_entry_flags) else $error("entry flags wrong");

  property p_nop_sleep;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == SPD_RUN && SLEEP_EXEC && irq_pending && !full_reset) |=>
      (state == SPD_RUN && $stable(POWERDOWN_FLAG_N) && !WATCHDOG_CLEAR);
  endproperty
  a_nop_sleep: assert property (p_nop_sleep) else $error("sleep not a no-op");

  property p_only_sleep_instr;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == SPD_RUN && !SLEEP_EXEC) |=> state != SPD_SLEEP;
  endproperty
  a_only_sleep_instr: assert property (p_only_sleep_instr) else $error("bad entry");

  property p_wdt_wake_clear;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == SPD_SLEEP && wake_sync && !full_reset) |=> WATCHDOG_CLEAR;
  endproperty
  a_wdt_wake_clear: assert property (p_wdt_wake_clear) else $error("no wdt clear");

  property p_ost_len;
    @(posedge CORE_CLK) disable iff (RESET || full_reset)
    (state == SPD_SYNC && need_ost) |=> (state == SPD_OST)[*8];
  endproperty
  a_ost_len: assert property (p_ost_len) else $error("start-up delay short");

  property p_clk_release;
    @(posedge CORE_CLK) disable iff (RESET)
    $rose(CORE_CLK_EN) |-> ($past(state) == SPD_RESUME || $past(full_reset));
  endproperty
  a_clk_release: assert property (p_clk_release) else $error("early clock");

  property p_reg_normal;
    @(posedge CORE_CLK) disable iff (RESET)
    (LP_INCOMPAT_ACTIVE || unregulated && state == SPD_RUN) |=> !REGULATOR_LOWPOWER;
  endproperty
  a_reg_normal: assert property (p_reg_normal) else $error("regulator low");

  property p_reset_wake;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == SPD_SLEEP && full_reset) |=> (DEVICE_RESET && state == SPD_RUN);
  endproperty
  a_reset_wake: assert property (p_reset_wake) else $error("no reset wake");

  property p_flag_set;
    @(posedge CORE_CLK) disable iff (RESET)
    (IRQ_EVENT[0] && !full_reset) |=> IRQ_FLAG[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_wdt_wake_to;
    @(posedge CORE_CLK) disable iff (RESET)
    (state == SPD_SLEEP && wake_sync && wdt_pipe[1] && !full_reset) |=> !TIMEOUT_FLAG_N;
  endproperty
  a_wdt_wake_to: assert property (p_wdt_wake_to) else $error("time-out flag kept");

endmodule

// ==== test/spd_core_model.sv ====
// Core-side model: sleep instruction issue and interrupt conditions
`timescale 1ns/1ps
module spd_core_model (
  input wire logic clk,
  input wire logic core_clk_en,
  output logic sleep_exec,
  output logic [14:0] core_pc,
  output logic [7:0] irq_event
);
  initial begin
    sleep_exec = 1'b0;
    core_pc = 15'h0000;
    irq_event = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // A gated core fetches nothing, so no sleep is issued then
  task automatic do_sleep(input logic [14:0] pc);
    if (core_clk_en !== 1'b1) return;
    @(posedge clk);
    sleep_exec <= 1'b1;
    core_pc <= pc; // Word after sleep holds a no-op
    @(posedge clk);
    sleep_exec <= 1'b0;
  endtask
  task automatic raise_irq(input logic [2:0] i);
    @(posedge clk);
    irq_event[i] <= 1'b1;
    @(posedge clk);
    irq_event[i] <= 1'b0;
  endtask
endmodule

// ==== test/tb_spd_sleep_ctrl.sv ====
// Self-checking bench for the sleep power-down controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_spd_sleep_ctrl;
  import spd_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, global_irq_enable = 1'b0;
  logic wdt_to = 1'b0, ext_pin = 1'b0, ext_en = 1'b0, bor = 1'b0, bor_en = 1'b0;
  logic por = 1'b0, incompat = 1'b0, t1_ok = 1'b1, conv_osc = 1'b1, clrwdt = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, irq_en = 8'h00, irq_clr = 8'h00;
  logic [7:0] io_out = 8'hA5, io_oe = 8'h0F, rdata, pin_out, pin_oe, irq_flag, irq_event;
  logic clk_en, dev_rst, wd_clr, wd_run, lfo_en, t1_run, conv_run, sleep_exec;
  logic prefetch_req, vector_req, reg_lp, pd_n, to_n;
  logic [14:0] prefetch_addr, vector_addr, core_pc;
  int err_count = 0;
  int tests_run = 0;
  always #25 core_clk = ~core_clk;
  spd_sleep_ctrl i_spd_sleep_ctrl (.CORE_CLK(core_clk), .RESET(reset), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
    .SLEEP_EXEC(sleep_exec), .CLRWDT_EXEC(clrwdt), .CORE_PC(core_pc),
    .GLOBAL_IRQ_ENABLE(global_irq_enable), .IRQ_EVENT(irq_event), .IRQ_ENABLE(irq_en),
    .IRQ_FLAG_CLR(irq_clr), .WATCHDOG_TIMEOUT(wdt_to), .EXTERNAL_RESET_PIN(ext_pin),
    .EXTERNAL_RESET_EN(ext_en), .BROWNOUT_RESET(bor), .BROWNOUT_EN(bor_en),
    .POWER_ON_RESET(por), .LP_INCOMPAT_ACTIVE(incompat), .TIMER1_SRC_SLEEP_OK(t1_ok),
    .CONVERTER_DEDICATED_OSC(conv_osc), .IO_OUT(io_out), .IO_OE(io_oe),
    .CORE_CLK_EN(clk_en), .DEVICE_RESET(dev_rst), .WATCHDOG_CLEAR(wd_clr),
    .WATCHDOG_RUN(wd_run), .LOW_FREQ_INTERNAL_OSC_EN(lfo_en), .TIMER1_RUN(t1_run),
    .CONVERTER_RUN(conv_run), .IO_PIN_OUT(pin_out), .IO_PIN_OE(pin_oe),
    .PREFETCH_REQ(prefetch_req), .PREFETCH_ADDR(prefetch_addr), .VECTOR_REQ(vector_req),
    .VECTOR_ADDR(vector_addr), .REGULATOR_LOWPOWER(reg_lp), .POWERDOWN_FLAG_N(pd_n),
    .TIMEOUT_FLAG_N(to_n), .IRQ_FLAG(irq_flag));
  spd_core_model i_spd_core_model (.clk(core_clk), .core_clk_en(clk_en),
    .sleep_exec(sleep_exec), .core_pc(core_pc), .irq_event(irq_event));
  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic clr;
    @(posedge core_clk);
    irq_clr <= 8'hFF;
    @(posedge core_clk);
    irq_clr <= 8'h00;
  endtask
  // Bounded: a wake that never comes ends the run
  task automatic wait_wake(output int n, output logic wc);
    n = 0;
    wc = 1'b0;
    while (clk_en !== 1'b1) begin
      cyc(1);
      n++;
      if (wd_clr === 1'b1) wc = 1'b1;
      if (n > 2000) begin
        err_count++;
        $display("BAD wake exp 1 got %h", clk_en);
        complete_run();
      end
    end
  endtask
  task automatic nap(input logic [7:0] cfg, input logic [7:0] rc, input logic g,
      input logic w, input logic inc, input int lo, input int hi, input logic lp);
    int n;
    logic wc;
    wr(SPD_REG_CONFIG, cfg);
    wr(SPD_REG_REGCTL, rc);
    global_irq_enable <= g;
    incompat <= inc;
    irq_en <= 8'h01;
    i_spd_core_model.do_sleep(15'h0123);
    #1;
    `CHK("gate", 1'b0, clk_en)
    `CHK("pd", 1'b0, pd_n)
    `CHK("to", 1'b1, to_n)
    `CHK("wclr", 1'b1, wd_clr)
    `CHK("pref", 1'b1, prefetch_req)
    `CHK("paddr", 15'h0124, prefetch_addr)
    io_out <= 8'h5A;
    io_oe <= 8'hF0;
    i_spd_core_model.raise_irq(3'd7);
    cyc(6);
    `CHK("held", 8'hA5, pin_out)
    `CHK("heldoe", 8'h0F, pin_oe)
    `CHK("nowake", 1'b0, clk_en)
    `CHK("flag7", 1'b1, irq_flag[7])
    `CHK("lfo", 1'b1, lfo_en)
    `CHK("t1", t1_ok, t1_run)
    `CHK("adc", conv_osc, conv_run)
    `CHK("wrun", cfg[0], wd_run)
    if (lp !== 1'bx) `CHK("reglp", lp, reg_lp)
    if (w) begin
      @(posedge core_clk);
      wdt_to <= 1'b1;
      @(posedge core_clk);
      wdt_to <= 1'b0;
    end else i_spd_core_model.raise_irq(3'd0);
    wait_wake(n, wc);
    `CHK("delay", 1'b1, n >= lo && n <= hi)
    `CHK("vec", g & ~w, vector_req)
    `CHK("vaddr", SPD_ISR_VECTOR, vector_addr)
    `CHK("wkclr", 1'b1, wc)
    `CHK("towk", ~w, to_n)
    `CHK("pdwk", 1'b0, pd_n)
    io_out <= 8'hA5;
    io_oe <= 8'h0F;
    clr();
  endtask
  // Sleep, then pulse one reset source for one cycle: 0 brown-out, 1 pin, 2 power-on
  task automatic rst_src(input int k, input logic ex);
    i_spd_core_model.do_sleep(15'h0200);
    @(posedge core_clk);
    if (k == 0) bor <= 1'b1;
    else if (k == 1) ext_pin <= 1'b1;
    else por <= 1'b1;
    @(posedge core_clk);
    bor <= 1'b0;
    ext_pin <= 1'b0;
    por <= 1'b0;
    #1;
    `CHK("rst", ex, dev_rst)
    cyc(3);
    `CHK("rstflags", {ex, ex, 1'b1}, {clk_en, pd_n, to_n})
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    int n;
    logic wc;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    rd(SPD_REG_REGCTL, d);
    `CHK("rcrst", SPD_REGCTL_RESET, d)
    wr(SPD_REG_REGCTL, 8'hFF);
    rd(SPD_REG_REGCTL, d);
    `CHK("rcrd", 8'h03, d)
    rd(SPD_REG_STATUS, d);
    `CHK("strst", 8'h03, d)
    rd(4'hF, d);
    `CHK("unmap", 8'h00, d)
    wr(SPD_REG_REGCTL, 8'h01);
    irq_en <= 8'h01;
    i_spd_core_model.raise_irq(3'd0);
    i_spd_core_model.raise_irq(3'd1);
    rd(SPD_REG_WAKE, d);
    `CHK("pend", 8'h01, d)
    i_spd_core_model.do_sleep(15'h0040);
    #1;
    `CHK("nop", 1'b1, clk_en)
    `CHK("noppd", 1'b1, pd_n)
    `CHK("nopwd", 1'b0, wd_clr)
    clr();
    fork
      i_spd_core_model.do_sleep(15'h0080);
      i_spd_core_model.raise_irq(3'd0);
    join
    #1;
    wait_wake(n, wc);
    `CHK("lateirq", 1'b1, n <= 10 && pd_n === 1'b0 && to_n === 1'b1 && wc)
    clr();
    t1_ok <= 1'b0;
    conv_osc <= 1'b0;
    nap(8'h01, 8'h01, 1'b0, 1'b0, 1'b0, 1, 10, 1'b0);
    t1_ok <= 1'b1;
    conv_osc <= 1'b1;
    nap(8'h02, 8'h01, 1'b1, 1'b0, 1'b0, 1, 10, 1'b0);
    nap(8'h05, 8'h01, 1'b0, 1'b1, 1'b0, 1, 10, 1'b0);
    nap(8'h06, 8'h01, 1'b0, 1'b0, 1'b0, 1024, 1040, 1'b0);
    nap(8'h08, 8'h01, 1'b1, 1'b0, 1'b0, 1024, 1040, 1'b0);
    nap(8'h0A, 8'h01, 1'b0, 1'b0, 1'b0, 1024, 1040, 1'b0);
    nap(8'h18, 8'h01, 1'b0, 1'b0, 1'b0, 1, 10, 1'b0);
    nap(8'h00, 8'h03, 1'b0, 1'b0, 1'b0, 100, 115, 1'b1);
    nap(8'h00, 8'h03, 1'b0, 1'b0, 1'b1, 1, 10, 1'b0);
    nap(8'h20, 8'h03, 1'b0, 1'b0, 1'b0, 1, 10, 1'bx);
    bor_en <= 1'b1;
    rst_src(0, 1'b1);
    rst_src(1, 1'b0);
    ext_en <= 1'b1;
    rst_src(1, 1'b1);
    rst_src(2, 1'b1);
    @(posedge core_clk);
    clrwdt <= 1'b1;
    @(posedge core_clk);
    clrwdt <= 1'b0;
    #1;
    `CHK("clrwdt", 1'b1, wd_clr)
    complete_run();
  end
endmodule
